// ==== bench/svi_bus_checker_sva.sv ====
// Assertions on the interface between the responder and the host end
`default_nettype none
module svi_bus_checker (
   // Clock and reset
   input wire logic       mclk,
   input wire logic       rst_b,
   // Interface signals
   input wire logic       combined_irq_n,
   input wire logic       vector_fetch_strobe_n,
   input wire logic [7:0] data,
   input wire logic       data_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////
   a_oe_follows_strobe: assert property (
      !vector_fetch_strobe_n |=> data_oe)
      else $error("data bus not driven during strobe");
   a_bus_released: assert property (
      vector_fetch_strobe_n [*2] |-> !data_oe)
      else $error("data bus driven without strobe");
   a_strobe_width: assert property (
      $fell(vector_fetch_strobe_n) |->
         !vector_fetch_strobe_n [*3] ##1 vector_fetch_strobe_n)
      else $error("strobe low time not three cycles");
   a_strobe_gap: assert property (
      $rose(vector_fetch_strobe_n) |-> vector_fetch_strobe_n [*2])
      else $error("gap between strobes too short");
   a_vector_steady: assert property (
      data_oe && $past(data_oe) |-> $stable(data))
      else $error("vector changed within one strobe");
   a_oe_rise_lag: assert property (
      $rose(data_oe) |->
         $past(vector_fetch_strobe_n, 2) && !$past(vector_fetch_strobe_n))
      else $error("data enable rose without a strobe edge");
   a_vector_codes: assert property (
      data_oe |-> data inside {8'hC3, 8'h00, 8'hFF}
         || (data[7:6] == 2'h3 && data[2:0] == 3'h7)
         || (data[7:5] == 3'h2 && data[1:0] == 2'h0))
      else $error("vector outside the supported code set");
   a_oe_fall_lag: assert property (
      $rose(vector_fetch_strobe_n) |-> data_oe ##1 !data_oe)
      else $error("data enable did not drop one cycle after strobe");
endmodule : svi_bus_checker
`default_nettype wire

// ==== bench/test_supplied_vector_interrupt_responder.sv ====
// Self-checking bench joining the responder and the host end to end
`default_nettype none
module test_supplied_vector_interrupt_responder;
   timeunit 1ns;
   timeprecision 100ps;
   import svi_pkg::*;
   logic [7:0]     irq_in = 8'h00, mask = 8'h00, req_status, vector_byte;
   logic           mclk = 1'b0, rst_b = 1'b0, ce = 1'b1, ack_start = 1'b0;
   logic           irq_enable = 1'b1, irq_pending, busy, mem_inhibit;
   logic           vector_valid;
   logic [1:0]     vector_index;
   svi_mode_type   mode = MODE_RESTART;
   svi_family_type family = FAM_DIRECT;
   int             failures = 0, checked = 0, cycles = 0;
   logic [31:0]    lfsr = 32'h321F;
   ////////////////////////////////////////////////////////////////////////
   svi_bus_if bus_if ();
   svi_responder svi_responder_inst (.mclk(mclk), .rst_b(rst_b), .ce(ce),
      .irq_in(irq_in), .mask(mask), .mode(mode), .req_status(req_status),
      .bus(bus_if.dev));
   svi_host svi_host_inst (.mclk(mclk), .rst_b(rst_b), .ce(ce),
      .family(family), .mode(mode), .irq_enable(irq_enable),
      .ack_start(ack_start), .irq_pending(irq_pending), .busy(busy),
      .mem_inhibit(mem_inhibit), .vector_byte(vector_byte),
      .vector_index(vector_index), .vector_valid(vector_valid),
      .bus(bus_if.host));
   svi_bus_checker svi_bus_checker_inst (.mclk(mclk), .rst_b(rst_b),
      .combined_irq_n(bus_if.combined_irq_n),
      .vector_fetch_strobe_n(bus_if.vector_fetch_strobe_n),
      .data(bus_if.data), .data_oe(bus_if.data_oe));
   ////////////////////////////////////////////////////////////////////////
   always #2.5 mclk = ~mclk;
   // Whole run needs well under ten thousand cycles
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         failures++;
         print_verdict();
      end
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   function automatic int lowest(input logic [7:0] v);
      lowest = 0;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) lowest = i;
      end
   endfunction : lowest
   function automatic logic [7:0] exp_vec(input svi_mode_type m,
                                          input int n, input int i);
      logic [7:0] tab;
      tab = 8'h40 + 8'(4 * n);
      case (m)
         MODE_RESTART: exp_vec = 8'hC7 | 8'(n << 3);
         MODE_JUMP3: exp_vec = (i == 0) ? 8'hC3 : (i == 1) ? tab : 8'h00;
         MODE_EXT_OPCODE: exp_vec = 8'hC3;
         default: exp_vec = tab;
      endcase
   endfunction : exp_vec
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   // One-cycle pulse: the latch must hold it without any width demand
   task automatic raise(input logic [7:0] bits);
      @(posedge mclk);
      irq_in <= bits;
      @(posedge mclk);
      irq_in <= 8'h00;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
   endtask : raise
   task automatic fetch(input int n);
      int got;
      got = 0;
      @(posedge mclk);
      ack_start <= 1'b1;
      @(posedge mclk);
      ack_start <= 1'b0;
      for (int c = 0; c < 40 && !(got > 0 && busy === 1'b0); c++) begin
         @(negedge mclk);
         if (busy === 1'b1) check("mem_inhibit", mem_inhibit, 1);
         if (vector_valid === 1'b1) begin
            check("index", vector_index, got);
            check("vector", vector_byte, exp_vec(mode, n, got));
            got++;
         end
      end
      check("bytes", got, (mode == MODE_JUMP3) ? 3 : 1);
      // Host pending copy lags the line, so let it settle
      repeat (4) @(posedge mclk);
      @(negedge mclk);
   endtask : fetch
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] bits;
      logic [7:0] live;
      int         w;
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      @(negedge mclk);
      check("idle irq", bus_if.combined_irq_n, 1);
      check("idle oe", bus_if.data_oe, 0);
      check("idle status", req_status, 8'h00);
      check("idle pending", irq_pending, 0);
      check("idle busy", busy, 0);
      // Every source through every vector mode, rotating host families
      for (int m = 0; m < 5; m++) begin
         for (int n = 0; n < 8; n++) begin
            @(posedge mclk);
            mode <= svi_mode_type'(m);
            family <= svi_family_type'(n % 3);
            raise(8'h01 << n);
            check("status", req_status, 32'h1 << n);
            check("irq low", bus_if.combined_irq_n, 0);
            check("pending", irq_pending, 1);
            fetch(n);
            check("cleared", req_status, 0);
            check("irq high", bus_if.combined_irq_n, 1);
            check("pending off", irq_pending, 0);
         end
      end
      // Corner: acknowledge refused while disabled, then while frozen;
      // a mask change during the freeze must not reach the line
      raise(8'h20);
      @(posedge mclk);
      irq_enable <= 1'b0;
      ack_start  <= 1'b1;
      @(posedge mclk);
      irq_enable <= 1'b1;
      ce         <= 1'b0;
      mask       <= 8'h20;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      check("refused busy", busy, 0);
      check("frozen irq", bus_if.combined_irq_n, 0);
      @(posedge mclk);
      ack_start <= 1'b0;
      mask      <= 8'h00;
      ce        <= 1'b1;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      check("frozen status", req_status, 8'h20);
      fetch(5);
      check("cleared", req_status, 8'h00);
      // Random simultaneous requests under random masks
      for (int r = 0; r < 30; r++) begin
         lfsr = lfsr_next(lfsr);
         bits = (lfsr[7:0] == 8'h00) ? 8'h80 : lfsr[7:0];
         @(posedge mclk);
         mask <= lfsr[15:8];
         mode <= svi_mode_type'(lfsr[18:16] % 3'h5);
         family <= svi_family_type'(lfsr[20:19] % 2'h3);
         raise(bits);
         check("status", req_status, bits);
         for (int p = 0; p < 2; p++) begin
            live = bits & ~mask;
            check("masked irq", bus_if.combined_irq_n, live == 0);
            while (live != 8'h00) begin
               w = lowest(live);
               fetch(w);
               live[w] = 1'b0;
               bits[w] = 1'b0;
               check("left", req_status, bits);
            end
            check("drained irq", bus_if.combined_irq_n, 1);
            @(posedge mclk);
            mask <= 8'h00;
            repeat (4) @(posedge mclk);
            @(negedge mclk);
         end
      end
      print_verdict();
   end
endmodule : test_supplied_vector_interrupt_responder
`default_nettype wire

// ==== design/svi_bus_if.sv ====
// Interrupt request, acknowledge and vector data signals between both ends
`default_nettype none
interface svi_bus_if;
   logic       combined_irq_n;
   logic       vector_fetch_strobe_n;
   logic [7:0] data;
   logic       data_oe;

   modport dev  (output combined_irq_n, data, data_oe,
                 input  vector_fetch_strobe_n);
   modport host (input  combined_irq_n, data, data_oe,
                 output vector_fetch_strobe_n);
endinterface : svi_bus_if
`default_nettype wire

// ==== design/svi_host.sv ====
// Host end: acknowledge strobe generation and vector collection
`default_nettype none
module svi_host
   import svi_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                    mclk,
   input  wire logic                    rst_b,
   input  wire logic                    ce,
   // User configuration
   input  wire svi_pkg::svi_family_type family,
   input  wire svi_pkg::svi_mode_type   mode,
   input  wire logic                    irq_enable,
   // User request
   input  wire logic                    ack_start,
   // User results
   output logic                         irq_pending,
   output logic                         busy,
   output logic                         mem_inhibit,
   output logic [7:0]                   vector_byte,
   output logic [1:0]                   vector_index,
   output logic                         vector_valid,
   // Device side
   svi_bus_if.host                      bus
);
   import svi_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ASSERT,
      ST_GAP
   } svi_host_st_type;

   typedef struct packed {
      svi_host_st_type st;
      logic [3:0]      cnt;
      logic [1:0]      pulse_no;
      logic            op_n;
      logic            io_n;
      logic            ba;
      logic            bs;
      logic            strobe_n;
      logic            inhibit;
      logic            irq_seen;
      logic [7:0]      vbyte;
      logic [1:0]      vidx;
      logic            vvalid;
      logic            busy;
   } svi_host_state_type;

   svi_host_state_type q;
   svi_host_state_type d;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic act;
      act      = 1'b0;
      d        = q;
      d.vvalid = 1'b0;
      d.irq_seen = !bus.combined_irq_n;

      unique case (q.st)
         ST_IDLE: begin
            if (ack_start && q.irq_seen && irq_enable) begin
               d.st       = ST_ASSERT;
               d.cnt      = STROBE_CYC - 4'h1;
               d.pulse_no = 2'h0;
               d.inhibit  = 1'b1;                               // R06
               act        = 1'b1;
            end
         end
         ST_ASSERT: begin
            act = 1'b1;
            if (q.cnt == 4'h0) begin
               act = 1'b0;
               if (bus.data_oe) begin
                  d.vbyte  = bus.data;
                  d.vidx   = q.pulse_no;
                  d.vvalid = 1'b1;
               end
               d.st  = ST_GAP;
               d.cnt = GAP_CYC - 4'h1;
            end else begin
               d.cnt = q.cnt - 4'h1;
            end
         end
         ST_GAP: begin
            if (q.cnt != 4'h0) begin
               d.cnt = q.cnt - 4'h1;
            end else if (q.pulse_no + 2'h1 < svi_pulses(mode)) begin
               // R07 R08 R09 R10
               d.st       = ST_ASSERT;
               d.cnt      = STROBE_CYC - 4'h1;
               d.pulse_no = q.pulse_no + 2'h1;
               act        = 1'b1;
            end else begin
               d.st      = ST_IDLE;
               d.inhibit = 1'b0;                                // R06
            end
         end
      endcase
      d.busy = (d.st != ST_IDLE);

      // Model the processor status outputs, then the glue that forms
      // the strobe from them
      d.op_n = !(act && family == FAM_SPLIT_STROBE);
      d.io_n = !(act && family == FAM_SPLIT_STROBE);
      d.ba   = act && family == FAM_BUS_STATUS;
      d.bs   = act && family == FAM_BUS_STATUS;
      unique case (family)
         FAM_SPLIT_STROBE: d.strobe_n = d.op_n | d.io_n;        // R12
         FAM_BUS_STATUS:   d.strobe_n = !(d.ba && d.bs);        // R13
         default:          d.strobe_n = !act;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         q          <= '0;
         q.st       <= ST_IDLE;
         q.op_n     <= 1'b1;
         q.io_n     <= 1'b1;
         q.strobe_n <= 1'b1;
      end else if (ce) begin
         q <= d;
      end
   end

   assign bus.vector_fetch_strobe_n = q.strobe_n;
   assign irq_pending  = q.irq_seen;
   assign busy         = q.busy;
   assign mem_inhibit  = q.inhibit;
   assign vector_byte  = q.vbyte;
   assign vector_index = q.vidx;
   assign vector_valid = q.vvalid;
endmodule : svi_host
`default_nettype wire

// ==== design/svi_pkg.sv ====
// Shared constants and types of the supplied vector interrupt responder
`default_nettype none
package svi_pkg;
   // Clock and timing
   localparam int          CLK_PERIOD_NS  = 5;
   localparam int          STROBE_NS      = 15;
   localparam int          GAP_NS         = 10;
   localparam logic [3:0]  STROBE_CYC     =
      4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0]  GAP_CYC        =
      4'((GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Request inputs
   localparam int          NUM_REQ        = 8;
   // Vector encodings
   localparam logic [7:0]  RESTART_BASE   = 8'hC7;
   localparam logic [7:0]  JUMP_OPCODE    = 8'hC3;
   localparam logic [7:0]  JUMP_PAGE      = 8'h00;
   localparam logic [7:0]  TABLE_BASE     = 8'h40;
   localparam logic [7:0]  TABLE_STEP     = 8'h04;
   localparam logic [7:0]  EMPTY_VECTOR   = 8'hFF;
   localparam logic [1:0]  JUMP3_BYTES    = 2'h3;
   localparam logic [1:0]  SINGLE_BYTES   = 2'h1;

   // How the vector is formed and how many strobes one fetch takes
   typedef enum logic [2:0] {
      MODE_RESTART,
      MODE_JUMP3,
      MODE_EXT_OPCODE,
      MODE_INDIRECT,
      MODE_RELATIVE
   } svi_mode_type;

   // How the host derives the acknowledge strobe
   typedef enum logic [1:0] {
      FAM_DIRECT,
      FAM_SPLIT_STROBE,
      FAM_BUS_STATUS
   } svi_family_type;

   // Strobes used by one vector fetch in a given mode
   function automatic logic [1:0] svi_pulses(input svi_mode_type m);
      svi_pulses = (m == MODE_JUMP3) ? JUMP3_BYTES : SINGLE_BYTES;
   endfunction : svi_pulses
endpackage : svi_pkg
`default_nettype wire

// ==== design/svi_responder.sv ====
// Device end: request latches, masking, priority and vector supply
//
// Operation
// R01: OR eight enabled requests into one line
// R02: Latch each request edge, no pulse width
// R03: Masked requests do not drive the line
// R04: Acknowledge returns highest-priority active vector
// R05: Strobe acts as vector memory read enable
// R06: Host inhibits main memory during acknowledge
// R07: Jump mode: one byte per strobe, three
// R08: Extended mode: strobe only on opcode byte
// R09: Indirect mode: one low address byte
// R10: Relative mode: one page-zero offset byte
// R11: Restart vectors reach only eight addresses
// R12: Split strobes: acknowledge when both low
// R13: Bus status: acknowledge when both high
// R14: Request states readable for polling
// R15: Data bus released while strobe inactive; here data_oe drops one cycle after the strobe rises
// R16: Active-low request drops when none pending
`default_nettype none
module svi_responder
   import svi_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                  mclk,
   input  wire logic                  rst_b,
   input  wire logic                  ce,
   // Peripheral requests, asynchronous pins
   input  wire logic [NUM_REQ-1:0]    irq_in,
   // Configuration from local logic
   input  wire logic [NUM_REQ-1:0]    mask,
   input  wire svi_pkg::svi_mode_type mode,
   // Poll port
   output logic      [NUM_REQ-1:0]    req_status,
   // Processor side
   svi_bus_if.dev                     bus
);
   import svi_pkg::*;

   typedef struct packed {
      // Request pins: two synchroniser stages, then the edge detector
      logic [NUM_REQ-1:0] sync1;
      logic [NUM_REQ-1:0] sync2;
      logic [NUM_REQ-1:0] prev;
      // Request latches and their poll copy
      logic [NUM_REQ-1:0] pend;
      logic [NUM_REQ-1:0] status;
      // Outputs to the processor side
      logic               irq_n;
      logic [7:0]         data;
      logic               oe;
      // Acknowledge tracking across the strobes of one fetch
      logic               strobe_prev;
      logic [2:0]         win;
      logic               win_ok;
      logic [1:0]         byte_no;
   } svi_dev_state_type;

   svi_dev_state_type q;
   svi_dev_state_type d;

   ////////////////////////////////////////////////////////////////////////////
   // Lowest index has highest priority
   // Returns 0 when nothing is active, so callers qualify it with |active
   function automatic logic [2:0] pick_highest(input logic [NUM_REQ-1:0] a);
      logic [2:0] r;
      r = 3'h0;
      for (int i = NUM_REQ - 1; i >= 0; i--) begin
         if (a[i]) begin
            r = 3'(i);
         end
      end
      pick_highest = r;
   endfunction : pick_highest

   // Vector memory contents for source n, byte b of the fetch
   function automatic logic [7:0] vec_byte(input svi_mode_type m,
                                            input logic [2:0]   n,
                                            input logic [1:0]   b);
      logic [7:0] tbl;
      tbl = 8'(TABLE_BASE + TABLE_STEP * {5'h00, n});
      unique case (m)
         MODE_RESTART: begin
            vec_byte = RESTART_BASE | {2'h0, n, 3'h0};          // R11
         end
         MODE_JUMP3: begin
            unique case (b)                                     // R07
               2'h0:    vec_byte = JUMP_OPCODE;
               2'h1:    vec_byte = tbl;
               default: vec_byte = JUMP_PAGE;
            endcase
         end
         MODE_EXT_OPCODE: begin
            // Remaining bytes come from the host's memory, not from here
            vec_byte = JUMP_OPCODE;                             // R08
         end
         MODE_INDIRECT: begin
            vec_byte = tbl;                                     // R09
         end
         MODE_RELATIVE: begin
            vec_byte = tbl;                                     // R10
         end
         default: begin
            // No legal mode: an all-ones byte is the safest code to supply
            vec_byte = EMPTY_VECTOR;
         end
      endcase
   endfunction : vec_byte

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [NUM_REQ-1:0] rise;
      logic [NUM_REQ-1:0] clr;
      logic [NUM_REQ-1:0] active;
      logic [2:0]         src;
      logic               start;
      logic               stop;
      logic               first;
      logic               have_src;
      rise     = '0;
      clr      = '0;
      active   = '0;
      src      = 3'h0;
      start    = 1'b0;
      stop     = 1'b0;
      first    = 1'b0;
      have_src = 1'b0;
      d        = q;

      // Pins pass two flops before the edge detector looks at them
      d.sync1 = irq_in;
      d.sync2 = q.sync1;
      d.prev  = q.sync2;
      // A level held high latches once; it must fall before it counts again
      rise    = q.sync2 & ~q.prev;                              // R02

      active = q.pend & ~mask;                                  // R03
      // Strobe edges are seen through one flop, so data_oe lags a cycle
      start  = !bus.vector_fetch_strobe_n && q.strobe_prev;
      stop   = bus.vector_fetch_strobe_n && !q.strobe_prev;
      d.strobe_prev = bus.vector_fetch_strobe_n;

      // Winner is frozen on the first strobe so a multibyte fetch
      // cannot mix bytes of two sources
      first    = (q.byte_no == 2'h0);
      have_src = first ? |active : q.win_ok;
      if (start) begin
         src = first ? pick_highest(active) : q.win;
         if (first) begin
            d.win    = src;
            d.win_ok = |active;
         end
         if (have_src) begin
            d.data = vec_byte(mode, src, q.byte_no);            // R04
         end else begin
            d.data = EMPTY_VECTOR;
         end
      end

      // The winner's latch clears only after the last strobe of the fetch
      if (stop) begin
         if (q.byte_no == svi_pulses(mode) - 2'h1) begin        // R07
            d.byte_no = 2'h0;
            if (q.win_ok) begin
               clr[q.win] = 1'b1;
            end
         end else begin
            d.byte_no = q.byte_no + 2'h1;
         end
      end

      // Only this end drives the vector, from one cycle after the strobe falls until one cycle after it rises
      d.oe = !bus.vector_fetch_strobe_n;                        // R05 R15

      // A new edge wins over the automatic clear
      d.pend   = (q.pend & ~clr) | rise;                        // R02
      d.status = d.pend;                                        // R14
      d.irq_n  = ~|(d.pend & ~mask);                            // R01 R16
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset acts even while ce is low; ce low freezes every field
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         // Edge detectors reset to the idle pin levels: no false edge
         q.sync1       <= '0;
         q.sync2       <= '0;
         q.prev        <= '0;
         q.pend        <= '0;
         q.status      <= '0;
         q.irq_n       <= 1'b1;
         q.data        <= 8'h00;
         q.oe          <= 1'b0;
         q.strobe_prev <= 1'b1;
         q.win         <= 3'h0;
         q.win_ok      <= 1'b0;
         q.byte_no     <= 2'h0;
      end else if (ce) begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Every bus output comes straight from a flop
   assign bus.combined_irq_n = q.irq_n;
   assign bus.data           = q.data;
   assign bus.data_oe        = q.oe;
   assign req_status         = q.status;
endmodule : svi_responder
`default_nettype wire
